// ---- shared/afhc_defs.vh ----
`ifndef AFHC_DEFS_VH
`define AFHC_DEFS_VH
// Word width and device depth
`define AFHC_WORD_W        9
`define AFHC_DEPTH         512
// Local buffer
`define AFHC_BUF_DEPTH     8
`define AFHC_BUF_AW        3
// Strobe timing in host clock cycles (50 ns each)
`define AFHC_STROBE_NS     50
`define AFHC_CLK_NS        50
`define AFHC_STROBE_CYC    ((`AFHC_STROBE_NS + `AFHC_CLK_NS - 1) / `AFHC_CLK_NS)
`define AFHC_CNT_W         4
`define AFHC_RESET_CYC     4'h4
`define AFHC_REPLAY_CYC    4'h4
`define AFHC_SAMPLE_CYC    4'h2
// Sequencer states
`define AFHC_ST_RESET      3'h0
`define AFHC_ST_IDLE       3'h1
`define AFHC_ST_WR         3'h2
`define AFHC_ST_RD         3'h3
`define AFHC_ST_REPLAY     3'h4
`define AFHC_ST_GAP        3'h5
`endif

// ---- hw/afhc_fifo.v ----
`timescale 1ns/10ps
// Small flip-flop FIFO with valid/ready on both sides
module afhc_fifo #(
   parameter WIDTH = 9,
   parameter DEPTH = 8,
   parameter AW    = 3
) (
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
   reg [AW-1:0]    wr_ptr_ff;
   reg [AW-1:0]    rd_ptr_ff;
   reg [AW:0]      count_ff;
   wire            push;
   wire            pop;

   assign in_ready  = (count_ff != DEPTH[AW:0]);
   assign out_valid = (count_ff != {(AW+1){1'b0}});
   assign out_data  = mem_ff[rd_ptr_ff];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge sys_clk) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data;
      end
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_ff <= {AW{1'b0}};
         rd_ptr_ff <= {AW{1'b0}};
         count_ff  <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
         end
         if (pop) begin
            rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
         end
         if (push & ~pop) begin
            count_ff <= count_ff + 1'b1;
         end else if (pop & ~push) begin
            count_ff <= count_ff - 1'b1;
         end
      end
   end
endmodule

// ---- hw/afhc_sync.v ----
`timescale 1ns/10ps
// Three-stage input synchroniser; output changes once stages two and three agree
module afhc_sync #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   input  wire             sys_clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] level_out
);
   reg [WIDTH-1:0] s1_ff;
   reg [WIDTH-1:0] s2_ff;
   reg [WIDTH-1:0] s3_ff;
   reg [WIDTH-1:0] lvl_ff;
   genvar i;

   assign level_out = lvl_ff;

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_ff <= INIT;
         s2_ff <= INIT;
         s3_ff <= INIT;
      end else begin
         s1_ff <= pin_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               lvl_ff[i] <= INIT[i];
            end else if (s2_ff[i] == s3_ff[i]) begin
               lvl_ff[i] <= s3_ff[i];
            end
         end
      end
   endgenerate
endmodule

// ---- hw/afhc_host.v ----
`timescale 1ns/10ps
`include "afhc_defs.vh"
module afhc_host #(
   parameter WORD_W    = `AFHC_WORD_W,
   parameter BUF_DEPTH = `AFHC_BUF_DEPTH,
   parameter BUF_AW    = `AFHC_BUF_AW,
   parameter DEPTH_CASCADE = 0
) (
   input  wire              sys_clk,
   input  wire              rst_n,
   // User side
   input  wire [WORD_W-1:0] usr_wr_data,
   input  wire              usr_wr_valid,
   output reg               usr_wr_ready_ff,
   output reg  [WORD_W-1:0] usr_rd_data_ff,
   output reg               usr_rd_valid_ff,
   input  wire              usr_rd_en,
   input  wire              usr_replay_req,
   input  wire              usr_reset_req,
   output reg               usr_busy_ff,
   output reg               usr_full_ff,
   output reg               usr_empty_ff,
   output reg               usr_half_ff,
   // Device pins
   output reg  [WORD_W-1:0] input_word_ff,
   output reg               write_strobe_n_ff,
   output reg               read_strobe_n_ff,
   input  wire [WORD_W-1:0] output_word,
   input  wire              full_flag_n,
   input  wire              empty_flag_n,
   input  wire              half_level_flag_n,
   output reg               master_reset_n_ff,
   output reg               replay_n_ff,
   output reg               expansion_in_n_ff,
   output reg               lead_device_sel_n_ff
);
   reg  [2:0]              state_ff;
   reg  [2:0]              nxt_state;
   reg  [`AFHC_CNT_W-1:0]  cnt_ff;
   reg  [`AFHC_CNT_W-1:0]  nxt_cnt;
   wire                    buf_push;
   wire [2:0]              flags_sync;
   wire                    dev_full;
   wire                    dev_empty;
   wire [WORD_W-1:0]       buf_data;
   wire                    buf_valid;
   wire                    buf_in_ready;
   reg                     buf_pop;
   reg                     rd_pending_ff;

   afhc_sync #(
      .WIDTH (3),
      .INIT  (3'h6)
   ) u_flag_sync (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .pin_in    ({full_flag_n, half_level_flag_n, empty_flag_n}),
      .level_out (flags_sync)
   );

   // Flags are sampled through the synchroniser; a flag may lag by four cycles
   assign dev_full  = ~flags_sync[2];
   assign dev_empty = ~flags_sync[0];
   // Push only on the user's registered ready, which drops after each push, so a held valid is taken every second cycle
   assign buf_push  = usr_wr_valid & usr_wr_ready_ff;

   afhc_fifo #(
      .WIDTH (WORD_W),
      .DEPTH (BUF_DEPTH),
      .AW    (BUF_AW)
   ) u_wr_buf (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .in_data   (usr_wr_data),
      .in_valid  (buf_push),
      .in_ready  (buf_in_ready),
      .out_data  (buf_data),
      .out_valid (buf_valid),
      .out_ready (buf_pop)
   );

   always @* begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      buf_pop   = 1'b0;
      case (state_ff)
         `AFHC_ST_RESET: begin
            if (cnt_ff == `AFHC_RESET_CYC) begin
               nxt_state = `AFHC_ST_GAP;
               nxt_cnt   = {`AFHC_CNT_W{1'b0}};
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         `AFHC_ST_IDLE: begin
            nxt_cnt = {`AFHC_CNT_W{1'b0}};
            if (usr_reset_req) begin
               nxt_state = `AFHC_ST_RESET;
            end else if (usr_replay_req && !DEPTH_CASCADE) begin
               nxt_state = `AFHC_ST_REPLAY;
            end else if (rd_pending_ff && !dev_empty) begin
               nxt_state = `AFHC_ST_RD;
            end else if (buf_valid && !dev_full) begin
               nxt_state = `AFHC_ST_WR;
               buf_pop   = 1'b1;
            end
         end
         `AFHC_ST_WR: begin
            if (cnt_ff == `AFHC_STROBE_CYC - 1) begin
               nxt_state = `AFHC_ST_GAP;
               nxt_cnt   = {`AFHC_CNT_W{1'b0}};
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         `AFHC_ST_RD: begin
            if (cnt_ff == `AFHC_SAMPLE_CYC) begin
               nxt_state = `AFHC_ST_GAP;
               nxt_cnt   = {`AFHC_CNT_W{1'b0}};
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         `AFHC_ST_REPLAY: begin
            if (cnt_ff == `AFHC_REPLAY_CYC) begin
               nxt_state = `AFHC_ST_GAP;
               nxt_cnt   = {`AFHC_CNT_W{1'b0}};
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         `AFHC_ST_GAP: begin
            // Wait for the flags to settle through the synchroniser
            if (cnt_ff == `AFHC_SAMPLE_CYC + 1'b1) begin
               nxt_state = `AFHC_ST_IDLE;
               nxt_cnt   = {`AFHC_CNT_W{1'b0}};
            end else begin
               nxt_cnt = cnt_ff + 1'b1;
            end
         end
         default: begin
            nxt_state = `AFHC_ST_IDLE;
            nxt_cnt   = {`AFHC_CNT_W{1'b0}};
         end
      endcase
   end

   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff             <= `AFHC_ST_RESET;
         cnt_ff               <= {`AFHC_CNT_W{1'b0}};
         rd_pending_ff        <= 1'b0;
         input_word_ff        <= {WORD_W{1'b0}};
         write_strobe_n_ff    <= 1'b1;
         read_strobe_n_ff     <= 1'b1;
         master_reset_n_ff    <= 1'b0;
         replay_n_ff          <= 1'b1;
         expansion_in_n_ff    <= 1'b1;
         lead_device_sel_n_ff <= 1'b1;
         usr_wr_ready_ff      <= 1'b0;
         usr_rd_data_ff       <= {WORD_W{1'b0}};
         usr_rd_valid_ff      <= 1'b0;
         usr_busy_ff          <= 1'b1;
         usr_full_ff          <= 1'b0;
         usr_empty_ff         <= 1'b1;
         usr_half_ff          <= 1'b0;
      end else begin
         state_ff          <= nxt_state;
         cnt_ff            <= nxt_cnt;
         // Single standalone device: expansion input tied inactive
         expansion_in_n_ff <= 1'b1;
         // Lead select low only for a first-loaded device of a depth cascade
         lead_device_sel_n_ff <= DEPTH_CASCADE ? 1'b0 : 1'b1;
         master_reset_n_ff <= (nxt_state != `AFHC_ST_RESET);
         // Both strobes stay high while replay is low
         replay_n_ff       <= (nxt_state != `AFHC_ST_REPLAY);
         write_strobe_n_ff <= (nxt_state != `AFHC_ST_WR);
         read_strobe_n_ff  <= (nxt_state != `AFHC_ST_RD);
         if (buf_pop) begin
            input_word_ff <= buf_data;
         end
         // Ready drops for a cycle after each push, then shows the updated room
         usr_wr_ready_ff   <= buf_in_ready & ~buf_push;
         // Read request latched until served
         if (usr_rd_en) begin
            rd_pending_ff <= 1'b1;
         end else if (state_ff == `AFHC_ST_RD && nxt_state == `AFHC_ST_GAP) begin
            rd_pending_ff <= 1'b0;
         end
         usr_rd_valid_ff <= 1'b0;
         // Data is taken at the last cycle of the low read strobe
         if (state_ff == `AFHC_ST_RD && nxt_state == `AFHC_ST_GAP) begin
            usr_rd_data_ff  <= output_word;
            usr_rd_valid_ff <= 1'b1;
         end
         usr_busy_ff  <= (nxt_state != `AFHC_ST_IDLE);
         usr_full_ff  <= dev_full;
         usr_empty_ff <= dev_empty;
         // Half level is meaningless in a depth cascade
         usr_half_ff  <= DEPTH_CASCADE ? 1'b0 : ~flags_sync[1];
      end
   end
endmodule

// ---- verification/afhc_dev_model.sv ----
`timescale 1ns/10ps
// Behavioural device at the far side, strobe-edge driven
module afhc_dev_model #(
   parameter DEPTH = 512
) (
   input  wire [8:0] input_word,
   input  wire       write_strobe_n,
   input  wire       read_strobe_n,
   input  wire       master_reset_n,
   input  wire       replay_n,
   output wire [8:0] output_word,
   output wire       full_flag_n,
   output wire       empty_flag_n,
   output wire       half_level_flag_n
);
   reg     [8:0] mem [0:DEPTH-1];
   reg     [8:0] q = 9'h000;
   integer       wp = 0;
   integer       rp = 0;
   // Released bus shows the inverse of the last word, so a late sample is caught
   assign output_word = read_strobe_n ? ~q : q;
   assign full_flag_n = (wp - rp) != DEPTH;
   assign empty_flag_n = wp != rp;
   // Standalone only; in a depth cascade this pin would carry the expansion output
   assign half_level_flag_n = (wp - rp) < DEPTH / 2;
   always @(negedge master_reset_n) begin
      wp = 0;
      rp = 0;
   end
   always @(negedge replay_n) if (master_reset_n) rp = 0;
   // Write and read ports run independently
   always @(posedge write_strobe_n) begin
      if (master_reset_n && (wp - rp) < DEPTH) begin
         mem[wp % DEPTH] = input_word;
         wp = wp + 1;
      end
   end
   always @(negedge read_strobe_n) begin
      if (master_reset_n && wp != rp) begin
         q = mem[rp % DEPTH];
         rp = rp + 1;
      end
   end
endmodule

// ---- verification/afhc_host_chk.sv ----
`timescale 1ns/10ps
module afhc_host_chk (
   input wire sys_clk,
   input wire rst_n,
   input wire usr_rd_valid_ff,
   input wire usr_reset_req,
   input wire usr_busy_ff,
   input wire usr_full_ff,
   input wire usr_empty_ff,
   input wire full_flag_n,
   input wire empty_flag_n,
   input wire write_strobe_n_ff,
   input wire read_strobe_n_ff,
   input wire master_reset_n_ff,
   input wire replay_n_ff,
   input wire expansion_in_n_ff,
   input wire lead_device_sel_n_ff
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_wr_pulse; $fell(write_strobe_n_ff) |=> write_strobe_n_ff; endproperty
   property p_rd_len; $fell(read_strobe_n_ff) |-> !read_strobe_n_ff [*3] ##1 read_strobe_n_ff; endproperty
   property p_rd_valid; $rose(read_strobe_n_ff) |-> ##[0:1] usr_rd_valid_ff; endproperty
   property p_replay_quiet; !replay_n_ff |-> write_strobe_n_ff && read_strobe_n_ff; endproperty
   property p_empty_sync; $fell(empty_flag_n) |-> ##[1:6] usr_empty_ff; endproperty
   property p_full_sync; $fell(full_flag_n) |-> ##[1:6] usr_full_ff; endproperty
   property p_rd_refused; $fell(read_strobe_n_ff) |=> !usr_empty_ff; endproperty
   property p_wr_refused; $fell(write_strobe_n_ff) |=> !usr_full_ff; endproperty
   property p_reset_go; usr_reset_req && !usr_busy_ff |-> ##[1:12] !master_reset_n_ff; endproperty
   property p_pins; expansion_in_n_ff && lead_device_sel_n_ff; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe width wrong");
   a_rd_len: assert property (p_rd_len) else $error("read strobe width wrong");
   a_rd_valid: assert property (p_rd_valid) else $error("read word not delivered");
   a_replay_quiet: assert property (p_replay_quiet) else $error("strobe low in replay");
   a_empty_sync: assert property (p_empty_sync) else $error("empty not seen");
   a_full_sync: assert property (p_full_sync) else $error("full not seen");
   a_rd_refused: assert property (p_rd_refused) else $error("read while empty");
   a_wr_refused: assert property (p_wr_refused) else $error("write while full");
   a_reset_go: assert property (p_reset_go) else $error("master reset not issued");
   a_pins: assert property (p_pins) else $error("expansion pins wrong");
   c_read: cover property ($rose(usr_rd_valid_ff));
   c_full: cover property ($rose(usr_full_ff));
   c_replay: cover property ($fell(replay_n_ff));
endmodule
bind afhc_host afhc_host_chk afhc_host_chk_inst (.sys_clk(sys_clk), .rst_n(rst_n), .usr_rd_valid_ff(usr_rd_valid_ff),
   .usr_reset_req(usr_reset_req), .usr_busy_ff(usr_busy_ff), .usr_full_ff(usr_full_ff), .usr_empty_ff(usr_empty_ff),
   .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n), .write_strobe_n_ff(write_strobe_n_ff),
   .read_strobe_n_ff(read_strobe_n_ff), .master_reset_n_ff(master_reset_n_ff), .replay_n_ff(replay_n_ff),
   .expansion_in_n_ff(expansion_in_n_ff), .lead_device_sel_n_ff(lead_device_sel_n_ff));

// ---- verification/afhc_host_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module afhc_host_tb_top;
   reg        sys_clk = 1'b0;
   reg        rst_n = 1'b0;
   reg  [8:0] usr_wr_data = 9'h000;
   reg        usr_wr_valid = 1'b0;
   reg        usr_rd_en = 1'b0;
   reg        usr_replay_req = 1'b0;
   reg        usr_reset_req = 1'b0;
   wire [8:0] usr_rd_data_ff, input_word_ff, output_word;
   wire       usr_wr_ready_ff, usr_rd_valid_ff, usr_busy_ff, usr_full_ff, usr_empty_ff, usr_half_ff;
   wire       write_strobe_n_ff, read_strobe_n_ff, master_reset_n_ff, replay_n_ff;
   wire       expansion_in_n_ff, lead_device_sel_n_ff, full_flag_n, empty_flag_n, half_level_flag_n;
   integer    err_total = 0;
   integer    cmp_count = 0;
   integer    i;
   integer    k;
   reg        seen;
   afhc_host afhc_host_inst (.sys_clk(sys_clk), .rst_n(rst_n), .usr_wr_data(usr_wr_data),
      .usr_wr_valid(usr_wr_valid), .usr_wr_ready_ff(usr_wr_ready_ff), .usr_rd_data_ff(usr_rd_data_ff),
      .usr_rd_valid_ff(usr_rd_valid_ff), .usr_rd_en(usr_rd_en), .usr_replay_req(usr_replay_req),
      .usr_reset_req(usr_reset_req), .usr_busy_ff(usr_busy_ff), .usr_full_ff(usr_full_ff),
      .usr_empty_ff(usr_empty_ff), .usr_half_ff(usr_half_ff), .input_word_ff(input_word_ff),
      .write_strobe_n_ff(write_strobe_n_ff), .read_strobe_n_ff(read_strobe_n_ff), .output_word(output_word),
      .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n), .half_level_flag_n(half_level_flag_n),
      .master_reset_n_ff(master_reset_n_ff), .replay_n_ff(replay_n_ff), .expansion_in_n_ff(expansion_in_n_ff),
      .lead_device_sel_n_ff(lead_device_sel_n_ff));
   afhc_dev_model afhc_dev_model_inst (.input_word(input_word_ff), .write_strobe_n(write_strobe_n_ff),
      .read_strobe_n(read_strobe_n_ff), .master_reset_n(master_reset_n_ff), .replay_n(replay_n_ff),
      .output_word(output_word), .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
      .half_level_flag_n(half_level_flag_n));
   initial forever #25 sys_clk = ~sys_clk;
   task test_done;
      if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task wait_idle;
      for (k = 0; k < 400 && usr_busy_ff !== 1'b0; k++) @(negedge sys_clk);
   endtask
   task wr(input [8:0] d);
      @(negedge sys_clk);
      usr_wr_data = d;
      usr_wr_valid = 1'b1;
      // Ready settled at a falling edge stands through the rising edge that takes the word
      for (k = 0; k < 400 && usr_wr_ready_ff !== 1'b1; k++) @(negedge sys_clk);
      `CHK("write ready", 1'b1, usr_wr_ready_ff)
      @(negedge sys_clk);
      usr_wr_valid = 1'b0;
   endtask
   task rd(input [8:0] ex);
      @(negedge sys_clk);
      usr_rd_en = 1'b1;
      @(negedge sys_clk);
      usr_rd_en = 1'b0;
      for (k = 0; k < 400 && usr_rd_valid_ff !== 1'b1; k++) @(negedge sys_clk);
      `CHK("read valid", 1'b1, usr_rd_valid_ff)
      `CHK("read word", ex, usr_rd_data_ff)
   endtask
   task t_order_replay;
      for (i = 0; i < 3; i++) wr(9'h1a5 ^ i[8:0]);
      for (i = 0; i < 3; i++) rd(9'h1a5 ^ i[8:0]);
      wait_idle;
      @(negedge sys_clk);
      usr_replay_req = 1'b1;
      @(negedge sys_clk);
      usr_replay_req = 1'b0;
      wait_idle;
      for (i = 0; i < 3; i++) rd(9'h1a5 ^ i[8:0]);
   endtask
   task t_fill_drain;
      for (i = 0; i < 512; i++) wr(i[8:0]);
      for (k = 0; k < 200 && usr_full_ff !== 1'b1; k++) @(negedge sys_clk);
      `CHK("full", 1'b1, usr_full_ff)
      `CHK("half", 1'b1, usr_half_ff)
      wr(9'h0aa);
      for (i = 0; i < 512; i++) rd(i[8:0]);
      rd(9'h0aa);
      for (k = 0; k < 200 && usr_empty_ff !== 1'b1; k++) @(negedge sys_clk);
      `CHK("empty", 1'b1, usr_empty_ff)
      `CHK("half clear", 1'b0, usr_half_ff)
   endtask
   task t_underflow;
      seen = 1'b0;
      @(negedge sys_clk);
      usr_rd_en = 1'b1;
      @(negedge sys_clk);
      usr_rd_en = 1'b0;
      for (k = 0; k < 30; k++) @(negedge sys_clk) if (read_strobe_n_ff !== 1'b1) seen = 1'b1;
      `CHK("read held", 1'b0, seen)
      wr(9'h123);
      for (k = 0; k < 400 && usr_rd_valid_ff !== 1'b1; k++) @(negedge sys_clk);
      `CHK("late read", 9'h123, usr_rd_data_ff)
   endtask
   task t_reset;
      wr(9'h055);
      for (k = 0; k < 200 && usr_empty_ff !== 1'b0; k++) @(negedge sys_clk);
      wait_idle;
      @(negedge sys_clk);
      usr_reset_req = 1'b1;
      @(negedge sys_clk);
      usr_reset_req = 1'b0;
      repeat (2) @(negedge sys_clk);
      wait_idle;
      `CHK("reset empty", 1'b1, usr_empty_ff)
      `CHK("reset full", 1'b0, usr_full_ff)
      `CHK("reset half", 1'b0, usr_half_ff)
      wr(9'h077);
      rd(9'h077);
   endtask
   initial begin
      repeat (12) @(negedge sys_clk);
      rst_n = 1'b1;
      wait_idle;
      t_order_replay;
      t_fill_drain;
      t_underflow;
      t_reset;
      test_done;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      err_total++;
      test_done;
   end
endmodule
